// >>> multichannel_dac_host_control.sv
// Host-facing control logic of a 40-channel 12-bit DAC
//
// Notes on behaviour
// RL1: Parallel write on strobe rise, select low
// RL2: Serial mode: strobe pin enables daisy chain
// RL3: I2C mode: strobe pin is upper address
// RL4: Data bus twelve bits, MSB highest
// RL5: Six address bits pick one of 40
// RL6: Register select picks input, offset, gain, special
// RL7: Serial output changes on clock rise
// RL8: Toggle parallel mode: pin selects A/B
// RL9: Toggle mode: each load swaps A/B
// RL10: Two data registers; A by default
// RL11: Busy low during calculation, no updates
// RL12: Writes still accepted during calculation
// RL13: Load while not busy updates outputs
// RL14: Load during calculation stored, done later
// RL15: Reset: busy low, interface off, loads dropped
// RL16: Clear edge loads clear code, 35 us
// RL17: Reset edge restores defaults, 270 us; the clear code register keeps its value
// RL18: After reset, wait for next edge
// RL19: Power-down: analog low power, output option
// RL20: Serial interface active during power-down
// RL21: Interface select high serial, low parallel
// RL22: Chip select honoured only while low
`timescale 1ns/1ps
`include "dac_host_consts.svh"
module multichannel_dac_host_control
   import dac_host_pkg::*;
#(
   parameter int RESET_CYCLES = `RESET_CYCLES,
   parameter int CLEAR_CYCLES = `CLEAR_CYCLES,
   parameter int NUM_CHANNELS = `NUM_CHANNELS
) (
   input  wire logic                mclk,             // Master clock, 25 MHz
   input  wire logic                rst_n,            // Power-on reset, active low
   input  wire logic                interfaceSelect,  // High serial, low parallel
   input  wire logic                chipSelect_n,     // Chip select / frame sync / addr low
   input  wire logic                writeStrobe,      // Write strobe / chain / addr high
   input  wire logic [`ADDR_W-1:0]  channelAddress,   // Channel address
   input  wire logic [1:0]          registerSelect,   // Register select
   input  wire logic [`DATA_W-1:0]  parallelDataBus,  // Data bus, bit 11 is MSB
   input  wire logic                abSelectIn,       // A/B select, input side of SERIAL_DATA_OUT pin
   input  wire logic                serialClock,      // Serial clock pin
   input  wire logic                serialDataIn,     // Serial data input pin
   input  wire logic                loadOutputs_n,    // Load DAC outputs
   input  wire logic                clearToCode_n,    // Clear to code
   input  wire logic                resetIn_n,        // Digital reset pin
   input  wire logic                powerDownIn,      // Power-down, active high
   input  wire logic                toggleMode,       // Toggle mode configuration
   input  wire logic                pdGroundOption,   // Power-down output loads ground
   output logic                     busy,             // Busy, low while working
   output logic                     chainEnable,      // Daisy chain enabled
   output logic                     busAddrPinUpper,  // I2C address bit from strobe pin
   output logic                     busAddrPinLower,  // I2C address bit from select pin
   output logic                     serialDataOut,    // Serial output level
   output logic                     serialDataOe,     // Serial output enable
   output logic                     toggleState,      // Data register now shown, 1 = B
   output dac_update_t              dacUpdate,        // DAC register update
   output power_ctrl_t              powerCtrl         // Analog power-down controls
);

   localparam int TW = $clog2(RESET_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // Apply gain and offset to an input code and clamp to full scale
   function automatic logic [`DATA_W-1:0] calibrate(input logic [11:0] x1,
                                                    input logic [11:0] gain,
                                                    input logic [11:0] offs);
      logic [24:0]        prod;
      logic signed [14:0] sum;
      prod = 25'(x1) * (25'(gain) + 25'h000_0001);
      sum  = $signed({2'h0, prod[24:12]}) + $signed({3'h0, offs}) - $signed(`MID_CODE);
      if (sum < 0) begin
         return 12'h000;
      end else if (sum > $signed(`CODE_MAX)) begin
         return 12'hFFF;
      end
      return sum[11:0];
   endfunction : calibrate

   // Lowest pending index, with a found flag on top
   function automatic logic [7:0] firstPending(input logic [127:0] p);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 127; i >= 0; i--) begin
         if (p[i]) begin
            r = {1'b1, 7'(i)};
         end
      end
      return r;
   endfunction : firstPending

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers

   logic [1:0]         rstSync;
   logic               rstInt_n;
   logic [`PIN_W-1:0]  pinMeta;
   logic [`PIN_W-1:0]  pinSync;
   logic [5:0]         edgePrev;

   // Reset enters asynchronously but is released through two flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstInt_n = rstSync[1];

   // Every pin except toggleMode and pdGroundOption passes two flops; the bus is assumed stable around the strobe
   always_ff @(posedge mclk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         pinMeta  <= '0;
         pinSync  <= '0;
         edgePrev <= '0;
      end else begin
         pinMeta  <= {interfaceSelect, chipSelect_n, writeStrobe, channelAddress,
                      registerSelect, parallelDataBus, abSelectIn, serialClock,
                      serialDataIn, loadOutputs_n, clearToCode_n, resetIn_n, powerDownIn};
         pinSync  <= pinMeta;
         edgePrev <= {pinSync[27], pinSync[5], pinSync[4:1]};
      end
   end

   // Named fields of the synchronised pins
   wire               serSel   = pinSync[29];
   wire               csN      = pinSync[28];
   wire               wrPin    = pinSync[27];
   wire [`ADDR_W-1:0] chan     = pinSync[26:21];
   wire [1:0]         regSel   = pinSync[20:19];
   wire [`DATA_W-1:0] dataWord = pinSync[18:7];                 // [RL4]
   wire               abPin    = pinSync[6];
   wire               sclk     = pinSync[5];
   wire               sdin     = pinSync[4];
   wire               ldacN    = pinSync[3];
   wire               clrN     = pinSync[2];
   wire               rstPinN  = pinSync[1];
   wire               pdPin    = pinSync[0];

   ////////////////////////////////////////////////////////////////////////////
   // Mode and write decode

   seq_state_t        state;
   seq_state_t        next_state;
   logic [127:0]      calcPend;
   logic [127:0]      next_pend;
   logic [6:0]        idx;
   logic [6:0]        next_idx;
   logic [6:0]        calcIdx;
   logic [TW-1:0]     timer;
   logic [TW-1:0]     next_timer;
   logic              ldacStored;
   logic              loadVld;
   logic [5:0]        loadChan;
   logic [11:0]       clearCode;
   logic [11:0]       inRd;
   logic [11:0]       offRd;
   logic [11:0]       gainRd;
   logic [11:0]       codeRd;
   logic [`CHAIN_W-1:0] chainShift;
   dac_update_t       next_upd;

   // Interface mode from the select pin and bit 9 of the bus
   wire parMode   = !serSel;                                     // [RL21]
   wire i2cMode   = serSel & dataWord[9];
   wire spiMode   = serSel & !dataWord[9];
   wire resetting = (state == ST_RESET);

   // Edges on the synchronised copies
   wire wrRise  = wrPin & !edgePrev[5];
   wire sclkRise = sclk & !edgePrev[4];
   wire sclkFall = !sclk & edgePrev[4];
   wire ldacFall = !ldacN & edgePrev[2];
   wire clrFall  = !clrN & edgePrev[1];
   wire rstFall  = !rstPinN & edgePrev[0];                       // [RL18]

   // A write is taken on the strobe rise, select low, interface enabled
   wire hostWrite  = parMode & !csN & wrRise & !resetting;       // [RL1] [RL22] [RL15]
   wire chanOk     = (chan < 6'(NUM_CHANNELS));                   // [RL5]
   wire abTarget   = toggleMode & abPin;                          // [RL8] [RL10]
   wire wrInput    = hostWrite & chanOk & (regSel == `REGSEL_INPUT);   // [RL6]
   wire wrOffset   = hostWrite & chanOk & (regSel == `REGSEL_OFFSET);
   wire wrGain     = hostWrite & chanOk & (regSel == `REGSEL_GAIN);
   wire wrClear    = hostWrite & (regSel == `REGSEL_SFR) & (chan == `SFR_CLEAR_CODE);
   wire [7:0] pick = firstPending(calcPend);
   wire startLoad  = (state == ST_IDLE) & (next_state == ST_LOAD);
   // Busy holds high through a load walk; calculations for later writes wait for it to end
   wire busyTerm   = ((state == ST_IDLE) & !pick[7]) | (state == ST_LOAD);   // [RL11]

   ////////////////////////////////////////////////////////////////////////////
   // Code memories

   // During reset the sequencer owns the write ports, the host is locked out
   wire [6:0]  inWrAddr  = resetting ? idx : {abTarget, chan};
   wire [11:0] inWrData  = resetting ? `DEF_INPUT : dataWord;
   wire [11:0] offWrData = resetting ? `DEF_OFFSET : dataWord;
   wire [11:0] gnWrData  = resetting ? `DEF_GAIN : dataWord;
   wire [6:0]  codeWrAddr = (state == ST_CALC) ? calcIdx : idx;
   wire [11:0] codeWrData = (state == ST_CALC) ? calibrate(inRd, gainRd, offRd) :
                            (state == ST_CLEAR) ? clearCode : `DEF_COMPUTED;
   wire        codeWrEn   = (state == ST_CALC) | (state == ST_CLEAR) | resetting;
   wire [6:0]  codeRdAddr = {toggleState, idx[5:0]};             // [RL9]

   dac_code_ram #(.WIDTH(12), .DEPTH(128), .AW(7)) uInputCodeReg (
      .clk    (mclk),
      .wrEn   (wrInput | resetting),                              // [RL12] [RL17]
      .wrAddr (inWrAddr),
      .wrData (inWrData),
      .rdAddr (pick[6:0]),
      .rdData (inRd)
   );

   dac_code_ram #(.WIDTH(12), .DEPTH(64), .AW(6)) uOffsetReg (
      .clk    (mclk),
      .wrEn   (wrOffset | resetting),
      .wrAddr (resetting ? idx[5:0] : chan),
      .wrData (offWrData),
      .rdAddr (pick[5:0]),
      .rdData (offRd)
   );

   dac_code_ram #(.WIDTH(12), .DEPTH(64), .AW(6)) uGainReg (
      .clk    (mclk),
      .wrEn   (wrGain | resetting),
      .wrAddr (resetting ? idx[5:0] : chan),
      .wrData (gnWrData),
      .rdAddr (pick[5:0]),
      .rdData (gainRd)
   );

   dac_code_ram #(.WIDTH(12), .DEPTH(128), .AW(7)) uComputedCodeReg (
      .clk    (mclk),
      .wrEn   (codeWrEn),
      .wrAddr (codeWrAddr),
      .wrData (codeWrData),
      .rdAddr (codeRdAddr),
      .rdData (codeRd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   // Reset beats clear, clear beats calculation, calculation beats load
   always_comb begin
      next_state = state;
      next_idx   = idx;
      next_timer = timer;
      case (state)
         ST_RESET: begin
            next_idx   = (idx == 7'h7F) ? idx : idx + 7'h01;
            next_timer = timer + TW'(1);
            if (timer == TW'(RESET_CYCLES - 1)) begin            // [RL17]
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            next_idx   = '0;
            next_timer = '0;
            if (pick[7]) begin
               next_state = ST_CALC;
            end else if (ldacStored) begin                       // [RL13] [RL14]
               next_state = ST_LOAD;
            end
         end
         ST_CALC: begin
            next_state = ST_IDLE;
         end
         ST_LOAD: begin
            next_idx = idx + 7'h01;
            if (idx == 7'(NUM_CHANNELS - 1)) begin
               next_state = ST_IDLE;
            end
         end
         ST_CLEAR: begin
            next_idx   = (idx == 7'h7F) ? idx : idx + 7'h01;
            next_timer = timer + TW'(1);
            if (timer == TW'(CLEAR_CYCLES - 1)) begin            // [RL16]
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_RESET;
         end
      endcase
      if (clrFall && !resetting) begin
         next_state = ST_CLEAR;
         next_idx   = '0;
         next_timer = '0;
      end
      if (rstFall) begin
         next_state = ST_RESET;
         next_idx   = '0;
         next_timer = '0;
      end
   end

   // Pending calculations; a new write wins over the retiring one
   always_comb begin
      next_pend = calcPend;
      if (state == ST_CALC) begin
         next_pend[calcIdx] = 1'b0;
      end
      if (wrInput) begin
         next_pend[{abTarget, chan}] = 1'b1;                     // [RL12]
      end
      if (wrOffset | wrGain) begin
         next_pend[{1'b0, chan}] = 1'b1;
         next_pend[{1'b1, chan}] = 1'b1;
      end
      if (resetting | rstFall) begin
         next_pend = '0;
      end
   end

   // Clear emits its code directly; a load emits what the memory returns
   always_comb begin
      next_upd = '0;
      if (loadVld) begin
         next_upd = '{valid: 1'b1, chan: loadChan, code: codeRd};
      end else if ((state == ST_CLEAR) && (idx < 7'(NUM_CHANNELS))) begin
         next_upd = '{valid: 1'b1, chan: idx[5:0], code: clearCode};
      end
   end

   always_ff @(posedge mclk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         state    <= ST_RESET;
         idx      <= '0;
         timer    <= '0;
         calcPend <= '0;
         calcIdx  <= '0;
      end else begin
         state    <= next_state;
         idx      <= next_idx;
         timer    <= next_timer;
         calcPend <= next_pend;
         calcIdx  <= pick[6:0];
      end
   end

   // Load events: stored any time except in reset, where they are dropped
   always_ff @(posedge mclk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         ldacStored <= 1'b0;
      end else if (resetting | rstFall) begin
         ldacStored <= 1'b0;                                     // [RL15]
      end else if (ldacFall) begin
         ldacStored <= 1'b1;                                     // [RL14]
      end else if (startLoad) begin
         ldacStored <= 1'b0;
      end
   end

   // A/B selection flips on every load in toggle mode, else stays on A
   always_ff @(posedge mclk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         toggleState <= 1'b0;
      end else if (resetting) begin
         toggleState <= 1'b0;
      end else if (startLoad) begin
         toggleState <= toggleMode & !toggleState;               // [RL9] [RL10]
      end
   end

   // Clear code register, written through the special function space
   always_ff @(posedge mclk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         clearCode <= `DEF_CLEAR;
      end else if (wrClear) begin
         clearCode <= dataWord;
      end
   end

   // Registered outputs of the update path and busy
   always_ff @(posedge mclk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         loadVld   <= 1'b0;
         loadChan  <= '0;
         dacUpdate <= '0;
         busy      <= 1'b0;
      end else begin
         loadVld   <= (state == ST_LOAD);
         loadChan  <= idx[5:0];
         dacUpdate <= next_upd;                                  // [RL13] [RL16]
         busy      <= busyTerm;                                  // [RL11] [RL15]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial chain, pin reuse and power-down

   // Shift on the serial clock fall, drive the output on its rise
   always_ff @(posedge mclk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         chainShift      <= '0;
         serialDataOut   <= 1'b0;
         serialDataOe    <= 1'b0;
         chainEnable     <= 1'b0;
         busAddrPinUpper <= 1'b0;
         busAddrPinLower <= 1'b0;
         powerCtrl       <= '0;
      end else begin
         if (spiMode && !csN && sclkFall && !resetting) begin    // [RL20]
            chainShift <= {chainShift[`CHAIN_W-2:0], sdin};
         end
         if (sclkRise) begin
            serialDataOut <= chainShift[`CHAIN_W-1];             // [RL7]
         end
         serialDataOe    <= spiMode & !csN;                      // [RL7] [RL8]
         chainEnable     <= spiMode & wrPin;                     // [RL2]
         busAddrPinUpper <= i2cMode & wrPin;                     // [RL3]
         busAddrPinLower <= i2cMode & csN;
         powerCtrl       <= '{lowPower: pdPin, highZ: pdPin & !pdGroundOption,
                              groundLoad: pdPin & pdGroundOption};   // [RL19]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_write_pending: assert property (@(posedge mclk) disable iff (!rstInt_n)   // [RL1]
      (wrInput && !rstFall) |=> calcPend[{$past(abTarget), $past(chan)}])
      else $error("input write did not queue a calculation");

   a_busy_calc: assert property (@(posedge mclk) disable iff (!rstInt_n)       // [RL11]
      (state == ST_CALC) |=> !busy)
      else $error("busy high during calculation");

   a_no_update_calc: assert property (@(posedge mclk) disable iff (!rstInt_n)  // [RL11]
      loadVld |-> busy)
      else $error("output update while busy low");

   a_load_outputs_n_stored: assert property (@(posedge mclk) disable iff (!rstInt_n)     // [RL14]
      (ldacFall && !resetting && !rstFall && (state == ST_CALC)) |=> ldacStored)
      else $error("load event during calculation was lost");

   a_reset_discard: assert property (@(posedge mclk) disable iff (!rstInt_n)   // [RL15]
      resetting |=> !ldacStored && !busy)
      else $error("load kept or busy high during reset");

   a_clear_busy: assert property (@(posedge mclk) disable iff (!rstInt_n)      // [RL16]
      (clrFall && !resetting && !rstFall) |=> (state == ST_CLEAR) ##1 (!busy)[*8])
      else $error("clear did not hold busy low");

   a_reset_hold: assert property (@(posedge mclk) disable iff (!rstInt_n)      // [RL17]
      (resetting && (timer < TW'(RESET_CYCLES - 1)) && !rstFall) |=> resetting)
      else $error("reset sequence ended early");

   a_chain_oe: assert property (@(posedge mclk) disable iff (!rstInt_n)        // [RL7]
      serialDataOe |-> $past(serSel) && !$past(dataWord[9]))
      else $error("serial output driven outside SPI mode");

   a_toggle_flip: assert property (@(posedge mclk) disable iff (!rstInt_n)     // [RL9]
      (startLoad && toggleMode && !resetting) |=> (toggleState != $past(toggleState)))
      else $error("toggle mode load did not swap A and B");

   a_i2c_addr: assert property (@(posedge mclk) disable iff (!rstInt_n)        // [RL3]
      (i2cMode && wrPin) |=> busAddrPinUpper)
      else $error("upper bus address not taken from strobe pin");

endmodule : multichannel_dac_host_control

// >>> dac_host_consts.svh
// Constants for the multichannel DAC host control block
`ifndef DAC_HOST_CONSTS_SVH
`define DAC_HOST_CONSTS_SVH

// Data path geometry
`define DATA_W          12
`define ADDR_W          6
`define NUM_CHANNELS    40
`define CODE_AW         7
`define PIN_W           30
`define CHAIN_W         24

// Register select decode
`define REGSEL_SFR      2'h0
`define REGSEL_GAIN     2'h1
`define REGSEL_OFFSET   2'h2
`define REGSEL_INPUT    2'h3

// Special function address that loads the clear code
`define SFR_CLEAR_CODE  6'h02

// Power-on defaults and calibration constants
`define DEF_INPUT       12'h000
`define DEF_GAIN        12'hFFF
`define DEF_OFFSET      12'h800
`define DEF_COMPUTED    12'h000
`define DEF_CLEAR       12'h000
`define MID_CODE        15'h0800
`define CODE_MAX        15'h0FFF

// Timing, derived from the 25 MHz master clock
`define MCLK_MHZ        25
`define CLEAR_TIME_NS   35000
`define RESET_TIME_NS   270000
`define CLEAR_CYCLES    ((`CLEAR_TIME_NS * `MCLK_MHZ) / 1000)
`define RESET_CYCLES    ((`RESET_TIME_NS * `MCLK_MHZ) / 1000)

`endif

// >>> dac_host_pkg.sv
// Types shared by the DAC host control design
package dac_host_pkg;
`include "dac_host_consts.svh"

   // Sequencer states
   typedef enum logic [2:0] {
      ST_RESET,
      ST_IDLE,
      ST_CALC,
      ST_LOAD,
      ST_CLEAR
   } seq_state_t;

   // One DAC register update as seen at the analog side
   typedef struct packed {
      logic                  valid;
      logic [`ADDR_W-1:0]    chan;
      logic [`DATA_W-1:0]    code;
   } dac_update_t;

   // Power-down controls towards the analog section
   typedef struct packed {
      logic                  lowPower;
      logic                  highZ;
      logic                  groundLoad;
   } power_ctrl_t;

endpackage : dac_host_pkg

// >>> dac_code_ram.sv
// Simple dual-port code memory with registered read data
`timescale 1ns/1ps
module dac_code_ram #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 128,
   parameter int AW    = 7
) (
   input  wire logic             clk,      // Master clock
   input  wire logic             wrEn,     // Write strobe
   input  wire logic [AW-1:0]    wrAddr,   // Write address
   input  wire logic [WIDTH-1:0] wrData,   // Write data
   input  wire logic [AW-1:0]    rdAddr,   // Read address
   output logic      [WIDTH-1:0] rdData    // Read data, one cycle late
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Write port
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Read port returns the old word on a same-address collision
   always_ff @(posedge clk) begin
      rdData <= mem[rdAddr];
   end

endmodule : dac_code_ram

// >>> dac_host_model.sv
// Host model that drives the parallel write port of the DAC block
`timescale 1ns/1ps
module dac_host_model (
   input  wire logic        mclk,   // Master clock
   output logic             cs_n,   // Chip select, active low
   output logic             wr,     // Write strobe
   output logic [5:0]       addr,   // Channel address
   output logic [1:0]       sel,    // Register select
   output logic [11:0]      data    // Data bus
);
   initial begin
      cs_n = 1'b1;
      wr = 1'b0;
      addr = 6'h00;
      sel = 2'h0;
      data = 12'h000;
   end
   // Whole write; slow edges because the block synchronises every pin this model drives
   task automatic write(input logic [5:0] a, input logic [1:0] r, input logic [11:0] d);
      @(negedge mclk);
      cs_n = 1'b0; // Held low across the strobe
      addr = a;
      sel = r;
      data = d;
      repeat (4) @(negedge mclk);
      wr = 1'b1; // Rising edge takes the word
      repeat (4) @(negedge mclk);
      wr = 1'b0;
      repeat (4) @(negedge mclk);
      cs_n = 1'b1;
      data = ~d; // Released bus must not look like a stale word
   endtask : write
   // Static pin levels for the serial and bus address modes
   task automatic setp(input logic c, input logic w, input logic [11:0] d);
      @(negedge mclk);
      cs_n = c;
      wr = w;
      data = d;
   endtask : setp
endmodule : dac_host_model

// >>> multichannel_dac_host_control_tb.sv
// Self-checking testbench for the DAC host control block
`timescale 1ns/1ps
module multichannel_dac_host_control_tb import dac_host_pkg::*;;
   logic        mclk = 1'b0, rst_n = 1'b0, ifSel = 1'b0, load_n = 1'b1, clr_n = 1'b1;
   logic        rstIn_n = 1'b1, pd = 1'b0, busy, chainEnable, addrUp, addrLo, togSt, oe;
   logic        hCs_n, hWr, ab = 1'b0, tog = 1'b0;
   logic [5:0]  hAddr;
   logic [1:0]  hSel;
   logic [11:0] hData, code;
   dac_update_t upd;
   power_ctrl_t pwr;
   int          bad_count = 0, comparisons = 0;
   always #20 mclk = ~mclk;
   dac_host_model u_host (.mclk(mclk), .cs_n(hCs_n), .wr(hWr), .addr(hAddr), .sel(hSel),
      .data(hData));
   // Short counts keep the run brief
   multichannel_dac_host_control #(.RESET_CYCLES(200), .CLEAR_CYCLES(50)) u_dut (
      .mclk(mclk), .rst_n(rst_n), .interfaceSelect(ifSel), .chipSelect_n(hCs_n),
      .writeStrobe(hWr), .channelAddress(hAddr), .registerSelect(hSel),
      .parallelDataBus(hData), .abSelectIn(ab), .serialClock(1'b0), .serialDataIn(1'b0),
      .loadOutputs_n(load_n), .clearToCode_n(clr_n), .resetIn_n(rstIn_n),
      .powerDownIn(pd), .toggleMode(tog), .pdGroundOption(1'b0), .busy(busy),
      .chainEnable(chainEnable), .busAddrPinUpper(addrUp), .busAddrPinLower(addrLo),
      .serialDataOut(), .serialDataOe(oe), .toggleState(togSt), .dacUpdate(upd), .powerCtrl(pwr));
   ////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // Bounded wait for busy high; running out ends the run
   task automatic waitBusy;
      int n;
      for (n = 0; n < 400 && busy !== 1'b1; n++) @(negedge mclk);
      if (n == 400) begin
         chk("busy wait", 12'h000, 12'h001);
         wrap_up();
      end
   endtask : waitBusy
   // Scans a fixed window for the last update of channel 39
   task automatic find(output logic [11:0] c);
      int n;
      c = 12'hFFF ^ 12'h5A5;
      for (n = 0; n < 300; n++) begin
         @(negedge mclk);
         if (upd.valid === 1'b1 && upd.chan === 6'h27) c = upd.code;
      end
   endtask : find
   task automatic loadFind(output logic [11:0] c);
      @(negedge mclk);
      load_n = 1'b0;
      repeat (4) @(negedge mclk);
      load_n = 1'b1;
      find(c);
   endtask : loadFind
   ////////////////////////////////////////////////////////////////////////////////////
   // Top channel, default gain and offset pass the code through unchanged
   task automatic tLoad;
      u_host.write(6'h27, 2'h3, 12'hA5C);
      waitBusy();
      loadFind(code);
      chk("load code", code, 12'hA5C);
      $display("test load done");
   endtask : tLoad
   // Strobe in serial mode must not write
   task automatic tRefuse;
      @(negedge mclk);
      ifSel = 1'b1;
      u_host.write(6'h27, 2'h3, 12'h111);
      ifSel = 1'b0;
      loadFind(code);
      chk("serial mode write", code, 12'hA5C);
      $display("test refuse done");
   endtask : tRefuse
   task automatic tClear;
      u_host.write(6'h02, 2'h0, 12'h3C3);
      waitBusy();
      clr_n = 1'b0;
      repeat (6) @(negedge mclk);
      chk("busy in clear", busy, 12'h000);
      find(code);
      clr_n = 1'b1;
      chk("clear code", code, 12'h3C3);
      waitBusy();
      $display("test clear done");
   endtask : tClear
   // Pin reuse in serial modes and the power-down controls
   task automatic tModes;
      ifSel = 1'b1;
      u_host.setp(1'b0, 1'b1, 12'h200);
      repeat (6) @(negedge mclk);
      chk("bus address pins", {addrUp, addrLo}, 12'h002);
      u_host.setp(1'b0, 1'b1, 12'h000);
      pd = 1'b1;
      repeat (6) @(negedge mclk);
      chk("chain enable", chainEnable, 12'h001);
      chk("sdo enable", oe, 12'h001);
      chk("power ctrl", pwr, 12'h006);
      pd = 1'b0;
      u_host.setp(1'b1, 1'b0, 12'h000);
      ifSel = 1'b0;
      repeat (6) @(negedge mclk);
      chk("sdo enable off", oe, 12'h000);
      $display("test modes done");
   endtask : tModes
   // Toggle mode: B written through the select pin, each load swaps A and B
   task automatic tToggle;
      tog = 1'b1;
      ab = 1'b1;
      u_host.write(6'h27, 2'h3, 12'h123);
      ab = 1'b0;
      loadFind(code);
      chk("toggle B code", code, 12'h123);
      chk("toggle state", togSt, 12'h001);
      loadFind(code);
      chk("toggle A code", code, 12'h000);
      tog = 1'b0;
      $display("test toggle done");
   endtask : tToggle
   // Pin reset held low: defaults return and the low level is then ignored
   task automatic tPinReset;
      rstIn_n = 1'b0;
      repeat (6) @(negedge mclk);
      chk("busy in reset seq", busy, 12'h000);
      waitBusy();
      repeat (8) @(negedge mclk);
      chk("busy after seq", busy, 12'h001);
      rstIn_n = 1'b1;
      loadFind(code);
      chk("default code", code, 12'h000);
      $display("test pin reset done");
   endtask : tPinReset
   initial begin
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      chk("busy at power-on", busy, 12'h000);
      waitBusy();
      tLoad();
      tRefuse();
      tClear();
      tModes();
      tPinReset();
      tToggle();
      wrap_up();
   end
endmodule : multichannel_dac_host_control_tb
